// *** verilog/mfx_regs.vh ***
// constants for the memory field extension control
`ifndef MFX_REGS_VH
`define MFX_REGS_VH
// io transfer opcode and select code
`define MFX_IO_OP         3'h6
`define MFX_SEL_CODE      3'h2
// command codes in instruction bits 9-11 (select code 2)
`define MFX_CMD_CHG_DATA_BIT  0
`define MFX_CMD_CHG_INSTR_BIT 1
`define MFX_CMD_READ      3'h4
// read sub-codes in instruction bits 6-8 for command 4
`define MFX_RD_DATA       3'h1
`define MFX_RD_INSTR      3'h2
`define MFX_RD_INTBUF     3'h3
`define MFX_RD_RESTORE    3'h4
// select code 0 commands (get and restore flags)
`define MFX_SEL_FLAGS     3'h0
`define MFX_CMD_GET_FLAGS 3'h4
`define MFX_CMD_RST_FLAGS 3'h5
// save field layout (bit 0 is msb, as numbered in the 12-bit word)
`define MFX_SAVE_WIDTH    7
// reset values
`define MFX_FIELD_RESET   3'h0
`define MFX_SAVE_RESET    7'h00
// cycle kinds presented by the processor
`define MFX_CYC_FETCH     2'h0
`define MFX_CYC_DEFER     2'h1
`define MFX_CYC_EXEC      2'h2
`endif

// *** verilog/mfx_iot_decode.v ***
// io transfer instruction decoder for the field extension control
`default_nettype none
`include "mfx_regs.vh"
module mfx_io_decode (
  // instruction word, bit 0 is msb
  input  wire [11:0] instr_in,
  input  wire        io_strobe_in,
  // decoded command pulses
  output wire        chg_data_out,
  output wire        chg_instr_out,
  output wire        rd_data_out,
  output wire        rd_instr_out,
  output wire        rd_save_out,
  output wire        restore_mem_out,
  output wire        get_flags_out,
  output wire        restore_flags_out
);
  wire [2:0] op    = instr_in[11:9];   // octal digit 1
  wire [2:0] sel   = instr_in[8:6];    // word bits 3-5
  wire [2:0] fld   = instr_in[5:3];    // word bits 6-8
  wire [2:0] cmd   = instr_in[2:0];    // word bits 9-11
  wire       is_io = io_strobe_in && (op == `MFX_IO_OP);
  // select code 2N: field bits take no part in selection
  wire       sel2  = is_io && (sel == `MFX_SEL_CODE);
  wire       rd    = sel2 && (cmd == `MFX_CMD_READ);
  assign chg_data_out    = sel2 && cmd[`MFX_CMD_CHG_DATA_BIT] && !cmd[2];
  assign chg_instr_out   = sel2 && cmd[`MFX_CMD_CHG_INSTR_BIT] && !cmd[2];
  assign rd_data_out     = rd && (fld == `MFX_RD_DATA);
  assign rd_instr_out    = rd && (fld == `MFX_RD_INSTR);
  assign rd_save_out     = rd && (fld == `MFX_RD_INTBUF);
  assign restore_mem_out = rd && (fld == `MFX_RD_RESTORE);
  // flags commands sit on select code 0, field 0
  wire       sel0  = is_io && (sel == `MFX_SEL_FLAGS) && (fld == 3'h0);
  assign get_flags_out     = sel0 && (cmd == `MFX_CMD_GET_FLAGS);
  assign restore_flags_out = sel0 && (cmd == `MFX_CMD_RST_FLAGS);
endmodule
`default_nettype wire

// *** verilog/mfx_addr_gate.v ***
// extended field address gating, updated only at timing pulse four
`default_nettype none
`include "mfx_regs.vh"
module mfx_addr_gate (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       tp4_in,
  input  wire       indirect_mri_in,
  input  wire [1:0] cycle_in,
  input  wire [2:0] instr_field_in,
  input  wire [2:0] data_field_in,
  output reg  [2:0] ema_out
);
  // data field only for execute cycle of indirect memory reference
  wire use_df = indirect_mri_in && (cycle_in == `MFX_CYC_EXEC);
  // latch address at tp4, hold through the memory cycle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ema_out <= `MFX_FIELD_RESET;
    end else if (tp4_in) begin
      ema_out <= use_df ? data_field_in : instr_field_in;
    end
  end
endmodule
`default_nettype wire

// *** verilog/mfx_field_ctrl.v ***
// memory field extension control top
`default_nettype none
`include "mfx_regs.vh"
module mfx_field_ctrl (
  // clock and reset
  input  wire        CORE_CLK_IN,
  input  wire        RESET_N_IN,
  // processor timing and events
  input  wire        TIMING_PULSE_FOUR_IN,
  input  wire        IOT_STROBE_IN,
  input  wire [11:0] INSTR_IN,
  input  wire [1:0]  CYCLE_IN,
  input  wire        INDIRECT_MRI_IN,
  input  wire        JUMP_DONE_IN,
  input  wire        INT_PC_STORE_IN,
  input  wire        TIME_SHARE_EN_IN,
  // console
  input  wire        CONSOLE_EXT_LOAD_IN,
  input  wire [11:0] CONSOLE_SWITCH_IN,
  // accumulator
  input  wire [11:0] ACCUMULATOR_IN,
  // outputs to memory and processor
  output wire [2:0]  EXTENDED_FIELD_ADDRESS_OUT,
  output reg  [11:0] DATA_OUT,
  output reg         DATA_OR_OUT,
  output reg         INT_INHIBIT_OUT,
  output reg         USER_MODE_FLAG_OUT,
  output reg  [2:0]  INSTRUCTION_FIELD_OUT,
  output reg  [2:0]  DATA_FIELD_OUT
);
  // register state
  reg  [2:0] instruction_field_buffer;   // staging for instruction field
  reg  [6:0] save_field;                 // {ub, if, df} bits 0..6 msb first
  reg        user_buffer_flag;           // staged user mode
  reg  [2:0] next_if;                    // next instruction field
  reg  [2:0] next_dfield;                // next data field
  reg  [2:0] next_buf;                   // next instruction field buffer
  reg  [6:0] next_save;                  // next save field
  reg        next_ub;                    // next user buffer flag
  reg        next_umode;                 // next user mode flag
  reg        next_inh;                   // next interrupt inhibit
  reg [11:0] next_data;                  // next read-back word
  reg        next_or;                    // next read-back strobe
  // decoded commands
  wire chg_data;                         // change data field
  wire chg_instr;                        // change instruction field
  wire rd_data;                          // read data field
  wire rd_instr;                         // read instruction field
  wire rd_save;                          // read interrupt buffer
  wire restore_mem;                      // restore memory field
  wire get_flags;                        // get flags
  wire restore_flags;                    // restore flags
  // decoder instance
  mfx_io_decode u_dec (
    .instr_in          (INSTR_IN),
    .io_strobe_in      (IOT_STROBE_IN),
    .chg_data_out      (chg_data),
    .chg_instr_out     (chg_instr),
    .rd_data_out       (rd_data),
    .rd_instr_out      (rd_instr),
    .rd_save_out       (rd_save),
    .restore_mem_out   (restore_mem),
    .get_flags_out     (get_flags),
    .restore_flags_out (restore_flags)
  );
  // address gating instance
  mfx_addr_gate u_gate (
    .clk_in          (CORE_CLK_IN),
    .rst_n_in        (RESET_N_IN),
    .tp4_in          (TIMING_PULSE_FOUR_IN),
    .indirect_mri_in (INDIRECT_MRI_IN),
    .cycle_in        (CYCLE_IN),
    .instr_field_in  (INSTRUCTION_FIELD_OUT),
    .data_field_in   (DATA_FIELD_OUT),
    .ema_out         (EXTENDED_FIELD_ADDRESS_OUT)
  );
  // field bits of instruction word, bits 6-8
  wire [2:0] memory_data_field_bits = INSTR_IN[5:3];
  // next-state logic, priority: console, interrupt, commands, jump
  always @* begin
    next_if     = INSTRUCTION_FIELD_OUT;
    next_dfield = DATA_FIELD_OUT;
    next_buf    = instruction_field_buffer;
    next_save   = save_field;
    next_ub     = user_buffer_flag;
    next_umode  = USER_MODE_FLAG_OUT;
    next_inh    = INT_INHIBIT_OUT;
    next_data   = 12'h000;
    next_or     = 1'b0;
    if (CONSOLE_EXT_LOAD_IN) begin
      // console writes instruction field directly
      next_if     = CONSOLE_SWITCH_IN[5:3];
      next_buf    = CONSOLE_SWITCH_IN[5:3];
      next_dfield = CONSOLE_SWITCH_IN[2:0];
    end else if (INT_PC_STORE_IN) begin
      // save then clear both fields
      next_save   = {user_buffer_flag, INSTRUCTION_FIELD_OUT, DATA_FIELD_OUT};
      next_if     = `MFX_FIELD_RESET;
      next_dfield = `MFX_FIELD_RESET;
      next_umode  = 1'b0;
    end else begin
      if (chg_data) begin
        next_dfield = memory_data_field_bits;
      end
      if (chg_instr) begin
        next_buf = memory_data_field_bits;
        next_inh = 1'b1;
      end
      if (restore_mem) begin
        next_buf    = save_field[5:3];
        next_dfield = save_field[2:0];
        if (TIME_SHARE_EN_IN) begin
          next_ub = save_field[6];
        end
      end
      if (restore_flags) begin
        next_ub     = ACCUMULATOR_IN[6];
        next_buf    = ACCUMULATOR_IN[5:3];
        next_dfield = ACCUMULATOR_IN[2:0];
        next_inh    = 1'b1;
      end
      if (rd_data) begin
        next_data = {6'h00, DATA_FIELD_OUT, 3'h0};
        next_or   = 1'b1;
      end
      if (rd_instr) begin
        next_data = {6'h00, INSTRUCTION_FIELD_OUT, 3'h0};
        next_or   = 1'b1;
      end
      if (rd_save) begin
        next_data = {5'h00, save_field};
        next_or   = 1'b1;
      end
      if (get_flags) begin
        // inhibit in bit 3, save field in bits 5-11; processor owns the rest
        next_data = {3'h0, INT_INHIBIT_OUT, 1'b0, save_field};
        next_or   = 1'b1;
      end
      if (JUMP_DONE_IN && !chg_instr && !restore_flags) begin
        // jump completes: buffer moves into field, inhibit lifts
        next_if    = instruction_field_buffer;
        next_umode = user_buffer_flag;
        next_inh   = 1'b0;
      end
    end
  end
  // state registers
  always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      INSTRUCTION_FIELD_OUT    <= `MFX_FIELD_RESET;
      DATA_FIELD_OUT           <= `MFX_FIELD_RESET;
      instruction_field_buffer <= `MFX_FIELD_RESET;
      save_field               <= `MFX_SAVE_RESET;
      user_buffer_flag         <= 1'b0;
      USER_MODE_FLAG_OUT       <= 1'b0;
      INT_INHIBIT_OUT          <= 1'b0;
      DATA_OUT                 <= 12'h000;
      DATA_OR_OUT              <= 1'b0;
    end else begin
      INSTRUCTION_FIELD_OUT    <= next_if;
      DATA_FIELD_OUT           <= next_dfield;
      instruction_field_buffer <= next_buf;
      save_field               <= next_save;
      user_buffer_flag         <= next_ub;
      USER_MODE_FLAG_OUT       <= next_umode;
      INT_INHIBIT_OUT          <= next_inh;
      DATA_OUT                 <= next_data;
      DATA_OR_OUT              <= next_or;
    end
  end
endmodule
`default_nettype wire

// *** verification/mfx_field_ctrl_checker.sv ***
// port assertions for the field extension control
`default_nettype none
module mfx_chk (
  // inputs from the processor and console
  input wire logic        CORE_CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        TIMING_PULSE_FOUR_IN,
  input wire logic        IOT_STROBE_IN,
  input wire logic [11:0] INSTR_IN,
  input wire logic [1:0]  CYCLE_IN,
  input wire logic        INDIRECT_MRI_IN,
  input wire logic        JUMP_DONE_IN,
  input wire logic        INT_PC_STORE_IN,
  input wire logic        CONSOLE_EXT_LOAD_IN,
  // outputs of the control
  input wire logic [2:0]  EXTENDED_FIELD_ADDRESS_OUT,
  input wire logic [11:0] DATA_OUT,
  input wire logic        DATA_OR_OUT,
  input wire logic        INT_INHIBIT_OUT,
  input wire logic [2:0]  INSTRUCTION_FIELD_OUT,
  input wire logic [2:0]  DATA_FIELD_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [2:0] ema = EXTENDED_FIELD_ADDRESS_OUT;
  wire [2:0] ifo = INSTRUCTION_FIELD_OUT;
  wire [2:0] dfo = DATA_FIELD_OUT;
  // events kept apart from io commands; console and interrupt outrank them, jump yields to change instruction field and restore flags
  wire ev = JUMP_DONE_IN | INT_PC_STORE_IN | CONSOLE_EXT_LOAD_IN;
  // select code 2 command with nothing competing
  wire s2 = IOT_STROBE_IN & (INSTR_IN[11:6] == 6'h32) & !ev;
  // execute cycle of an indirect memory instruction at pulse four
  wire dsel = TIMING_PULSE_FOUR_IN & INDIRECT_MRI_IN & (CYCLE_IN == 2'h2);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_ema_hold; !TIMING_PULSE_FOUR_IN |=> $stable(ema); endproperty
  a_ema_hold: assert property (p_ema_hold) else $error("address moved off pulse four");
  property p_ema_df; dsel |=> ema == $past(dfo); endproperty
  a_ema_df: assert property (p_ema_df) else $error("address not data field");
  property p_ema_if; TIMING_PULSE_FOUR_IN & !dsel |=> ema == $past(ifo); endproperty
  a_ema_if: assert property (p_ema_if) else $error("address not instruction field");
  property p_chg_data; s2 & INSTR_IN[0] & !INSTR_IN[2] |=> dfo == $past(INSTR_IN[5:3]); endproperty
  a_chg_data: assert property (p_chg_data) else $error("data field not loaded");
  property p_chg_instr; s2 & INSTR_IN[1] & !INSTR_IN[2] |=> $stable(ifo) && INT_INHIBIT_OUT; endproperty
  a_chg_instr: assert property (p_chg_instr) else $error("field change not buffered");
  property p_jmp; JUMP_DONE_IN & !IOT_STROBE_IN & !INT_PC_STORE_IN & !CONSOLE_EXT_LOAD_IN |=> !INT_INHIBIT_OUT; endproperty
  a_jmp: assert property (p_jmp) else $error("inhibit kept after jump");
  property p_int; INT_PC_STORE_IN & !CONSOLE_EXT_LOAD_IN |=> ifo == 3'h0 && dfo == 3'h0; endproperty
  a_int: assert property (p_int) else $error("fields not cleared");
  property p_rd_data; s2 & (INSTR_IN[5:0] == 6'h0c) |=> DATA_OR_OUT && DATA_OUT == {6'h00, $past(dfo), 3'h0}; endproperty
  a_rd_data: assert property (p_rd_data) else $error("data field read wrong");
endmodule
bind mfx_field_ctrl mfx_chk mfx_chk_i (.*);
`default_nettype wire

// *** verification/mfx_acc_model.sv ***
// processor accumulator taking field values from the control
`default_nettype none
module mfx_acc_model (
  // clock and bench load
  input  wire logic        clk_in,
  input  wire logic        load_in,
  input  wire logic [11:0] load_val_in,
  // read-back from the control
  input  wire logic [11:0] data_in,
  input  wire logic        data_or_in,
  // accumulator to the control
  output var  logic [11:0] acc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // load from the bench, else merge the read-back
  always @(posedge clk_in) begin
    if (load_in) begin
      acc_out <= load_val_in;
    end else if (data_or_in) begin
      acc_out <= acc_out | data_in;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the field extension control
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, tp4 = 0, io_stb = 0, ts = 0, jump = 0, intr = 0, con = 0, ld = 1, ind = 0;
  logic [1:0] cyc = 0;
  logic [11:0] ins = 0, sw = 0, acc, dout;
  logic [2:0] ema, ifo, dfo;
  logic dor, inh, ufl;
  // reference model state
  int mismatches, n_checks, i, f_if, f_dat, f_buf, sfm, ub, ufm, hb, hok, ibok, e_ema, e_acc, e_d;
  logic [11:0] codes [13] = '{0, 0, 0, 12'hc8c, 12'hc94, 12'hc9c, 12'hca4, 12'hc04, 12'hc05, 0, 0, 0, 12'hcc2};
  always #25 clk = ~clk;
  mfx_field_ctrl mfx_field_ctrl_i (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .TIMING_PULSE_FOUR_IN(tp4),
    .IOT_STROBE_IN(io_stb), .INSTR_IN(ins), .CYCLE_IN(cyc), .INDIRECT_MRI_IN(ind), .JUMP_DONE_IN(jump),
    .INT_PC_STORE_IN(intr), .TIME_SHARE_EN_IN(ts), .CONSOLE_EXT_LOAD_IN(con), .CONSOLE_SWITCH_IN(sw),
    .ACCUMULATOR_IN(acc), .EXTENDED_FIELD_ADDRESS_OUT(ema), .DATA_OUT(dout), .DATA_OR_OUT(dor),
    .INT_INHIBIT_OUT(inh), .USER_MODE_FLAG_OUT(ufl), .INSTRUCTION_FIELD_OUT(ifo), .DATA_FIELD_OUT(dfo));
  mfx_acc_model mfx_acc_model_i (.clk_in(clk), .load_in(ld), .load_val_in(sw), .data_in(dout),
    .data_or_in(dor), .acc_out(acc));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // reset for 20 cycles and clear the model
  task automatic do_reset;
    rst_n = 0;
    {f_if, f_dat, f_buf, sfm, ub, ufm, hb, e_ema} = 0;
    hok = 1;
    ibok = 1;
    repeat (20) @(negedge clk);
    ld = 0;
    rst_n = 1;
    chk({dor, inh, ufl, ema, ifo, dfo}, 0);
  endtask
  // one operation: drive at the falling edge, compare at the next one
  task automatic step(input int k);
    logic [2:0] n;
    n = 3'($urandom);
    if (k == 10 && (hb != 0 || hok == 0)) k = 9; // processor holds off inhibited interrupts
    if (k == 7 && hok == 0) k = 5;
    if (k == 9 && ibok == 0) k = 1;
    @(negedge clk);
    chk(acc, e_acc);
    tp4 = 1'($urandom);
    cyc = 2'($urandom % 3);
    ind = 1'($urandom);
    ts = 1'($urandom);
    sw = 12'($urandom);
    io_stb = k < 9 || k == 12;
    ins = k < 3 ? {6'h32, n, 3'(k + 1)} : codes[k];
    jump = k == 9;
    intr = k == 10;
    con = k == 11;
    if (tp4) e_ema = ind && cyc == 2 ? f_dat : f_if;
    e_d = -1;
    if (k == 0 || k == 2) f_dat = n;
    if (k == 1 || k == 2) f_buf = n;
    if (k == 1 || k == 2 || k == 8) begin
      hb = 1;
      hok = 1;
      ibok = 1;
    end
    case (k)
      3: e_d = f_dat << 3;
      4: e_d = f_if << 3;
      5: e_d = sfm;
      6: begin
        f_buf = sfm >> 3 & 7;
        f_dat = sfm & 7;
        if (ts) ub = sfm >> 6;
        hok = 0;
        ibok = 1;
      end
      7: e_d = sfm | hb << 8;
      8: begin
        ub = e_acc >> 6 & 1;
        f_buf = e_acc >> 3 & 7;
        f_dat = e_acc & 7;
      end
      9: begin
        f_if = f_buf;
        ufm = ub;
        hb = 0;
        hok = 1;
      end
      10: begin
        sfm = ub << 6 | f_if << 3 | f_dat;
        f_if = 0;
        f_dat = 0;
        ufm = 0;
        ibok = 0;
      end
      11: begin
        f_if = sw[5:3];
        f_buf = f_if;
        f_dat = sw[2:0];
        ibok = 1;
      end
      default: ;
    endcase
    @(negedge clk);
    io_stb = 0;
    jump = 0;
    intr = 0;
    con = 0;
    tp4 = 0;
    chk(ifo, f_if);
    chk(dfo, f_dat);
    chk(ema, e_ema);
    chk(ufl, ufm);
    chk(dor, e_d >= 0);
    if (hok) chk(inh, hb);
    if (e_d >= 0) chk(dout, e_d);
    if (e_d >= 0) e_acc |= e_d;
  endtask
  initial begin
    i = $urandom(32'h0000_f71c);
    sw = 12'($urandom);
    e_acc = sw;
    do_reset();
    repeat (2) begin
      repeat (400) step($urandom % 13);
      do_reset();
    end
    end_of_test();
  end
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
